/* File: logic/dci_cmd_addr_if.sv */
// device-side command, address and data-path logic of a x16 eight-bank ddr3 part
// assumes link_clk is the true clock (rise = complement fall) from the controller,
// and that pads split dq/dqs into rise and fall halves of each link cycle
//
// Behaviour
// RL1: inputs sampled on true-clock rising crossing only
// RL2: read data given for both clock crossings
// RL3: clock enable low freezes state next cycle
// RL4: idle banks plus cke low enter low power
// RL5: bank field steers every bank command
// RL6: activate takes row from address bits 0-11
// RL7: column taken from address bits 0-9
// RL8: mode register set loads address opcode
// RL9: bit 10 on access requests auto-precharge
// RL10: bit 10 on precharge closes all banks
// RL11: bit 12 low chops burst on the fly
// RL12: burst lengths four and eight supported
// RL13: sequential or interleaved burst order selectable
// RL14: additive latency zero, CL-1 or CL-2
// RL15: controller refreshes 8192 times per 64 ms
// RL16: hot range needs 8192 refreshes per 32 ms
// RL17: eight banks each keep own open row
// RL18: column latency 9, 11 or 13 cycles
// RL19: each access prefetches eight data words
// RL20: sender drives the data strobe
// RL21: sixteen-bit data bus, eight banks
// RL22: chip select high masks every command
// RL23: row strobe low decodes activate or precharge
// RL24: column strobe low decodes read or write
// RL25: masked write bytes are discarded
// RL26: controller waits activate and precharge periods
// RL27: controller closes row before another activate
`timescale 1ns/1ns

module dci_cmd_addr_if #(
	parameter int OVERDUE_NORMAL_CYC = dci_pkg::OVERDUE_NORMAL_CYC,
	parameter int OVERDUE_EXT_CYC = dci_pkg::OVERDUE_EXT_CYC
) (
	// core clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// core-side status
	input wire logic extended_temp,
	output dci_pkg::dci_status_t status,
	// link side
	input wire logic link_clk,
	input wire dci_pkg::dci_cmd_pins_t cmd_pins,
	input wire dci_pkg::dci_wdata_t wdata,
	output dci_pkg::dci_rdata_t rdata
);
	import dci_pkg::*;

	// ==========================================
	// decoding helpers
	function automatic dci_cmd_t decode(input dci_cmd_pins_t p);
		dci_cmd_t c;
		c = CMD_NOP;
		if (p.cs_n) begin // RL22
			c = CMD_NOP;
		end else if (!p.ras_n && p.cas_n) begin // RL23
			c = p.we_n ? CMD_ACT : CMD_PRE;
		end else if (p.ras_n && !p.cas_n) begin // RL24
			c = p.we_n ? CMD_RD : CMD_WR;
		end else if (!p.ras_n && !p.cas_n) begin
			c = p.we_n ? CMD_REF : CMD_MRS;
		end
		return c;
	endfunction

	// column within the prefetch group for beat i
	function automatic logic [2:0] beat_col(input logic [2:0] start, input logic [2:0] i, input logic inter);
		logic [2:0] r;
		r = {start[2] ^ i[2], start[1:0] + i[1:0]};
		if (inter) begin // RL13
			r = start ^ i;
		end
		return r;
	endfunction

	// bytes with mask high keep the old contents
	function automatic logic [DQ_W-1:0] merge(input logic [DQ_W-1:0] old, input logic [DQ_W-1:0] d,
		input logic [1:0] mask);
		logic [DQ_W-1:0] r;
		r = old;
		if (!mask[0]) begin // RL25
			r[7:0] = d[7:0];
		end
		if (!mask[1]) begin // RL25
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	function automatic logic [4:0] cl_cycles(input logic [1:0] code);
		logic [4:0] r;
		case (code) // RL18
			2'h0: r = CL_667;
			2'h1: r = CL_800;
			default: r = CL_933;
		endcase
		return r;
	endfunction

	// ==========================================
	// link domain reset, released on the link clock
	logic [1:0] link_rst_sync;
	logic link_rst_n;

	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			link_rst_sync <= 2'h0;
		end else begin
			link_rst_sync <= {link_rst_sync[0], 1'b1};
		end
	end
	assign link_rst_n = link_rst_sync[1];

	// ==========================================
	// link domain state
	typedef struct packed {
		logic cke_prev;
		dci_pwr_t pwr;
		logic [3:0][ADDR_W-1:0] mr;
		logic [BANKS-1:0] bank_open;
		logic [BANKS-1:0][ROW_W-1:0] open_row;
		logic ref_tgl;
		logic busy;
		logic is_write;
		logic [4:0] wait_cnt;
		logic [1:0] beat;
		logic [1:0] last_beat;
		logic [BA_W-1:0] bank;
		logic [COL_W-1:0] col;
		logic auto_pre;
		logic [BURST-1:0][DQ_W-1:0] pf;
		logic [MEM_WORDS-1:0][DQ_W-1:0] mem; // RL21
		dci_rdata_t rd;
	} dci_link_t;

	dci_link_t l;
	dci_link_t next_l;
	dci_cmd_t cmd;
	logic [4:0] cl;
	logic [4:0] al;
	logic [4:0] lat;
	logic chop;
	logic [1:0] bl_mode;
	logic [2:0] i0;
	logic [2:0] i1;
	logic [5:0] w0;
	logic [5:0] w1;

	assign cmd = decode(cmd_pins);
	assign bl_mode = l.mr[0][MR_BL_LSB +: 2];
	assign cl = cl_cycles(l.mr[0][MR_CL_LSB +: 2]);
	assign lat = cl + al;
	assign i0 = {l.beat, 1'b0};
	assign i1 = {l.beat, 1'b1};
	assign w0 = {l.bank, beat_col(l.col[2:0], i0, l.mr[0][MR_BT_BIT])};
	assign w1 = {l.bank, beat_col(l.col[2:0], i1, l.mr[0][MR_BT_BIT])};

	always_comb begin
		case (l.mr[1][MR_AL_LSB +: 2]) // RL14
			AL_CL1: al = cl - LAT_ONE;
			AL_CL2: al = cl - LAT_TWO;
			default: al = 5'h00;
		endcase
		// RL11 RL12
		chop = (bl_mode == BL_FIXED4) || ((bl_mode == BL_OTF) && !cmd_pins.addr[CHOP_BIT]);
	end

	always_comb begin
		next_l = l;
		next_l.cke_prev = cmd_pins.cke;
		next_l.rd.dq_oe = 1'b0;
		next_l.rd.dqs_oe = 1'b0;
		if (!l.cke_prev) begin
			// suspended: only clock enable is watched
			if (cmd_pins.cke) begin // RL3
				next_l.pwr = PWR_ON;
			end
			next_l.rd.dq_oe = l.rd.dq_oe;
			next_l.rd.dqs_oe = l.rd.dqs_oe;
		end else begin
			// burst engine
			if (l.busy) begin
				if (l.wait_cnt != 5'h00) begin
					next_l.wait_cnt = l.wait_cnt - LAT_ONE;
				end else begin
					if (l.is_write) begin
						next_l.mem[w0] = merge(l.mem[w0], wdata.rise, wdata.byte_write_mask_rise);
						next_l.mem[w1] = merge(l.mem[w1], wdata.fall, wdata.byte_write_mask_fall);
					end else begin
						next_l.rd.rise = l.pf[i0]; // RL2
						next_l.rd.fall = l.pf[i1]; // RL2
						next_l.rd.dq_oe = 1'b1;
						next_l.rd.dqs_rise = 1'b1; // RL20
						next_l.rd.dqs_fall = 1'b0;
						next_l.rd.dqs_oe = 1'b1; // RL20
					end
					next_l.beat = l.beat + 2'h1;
					if (l.beat == l.last_beat) begin
						next_l.busy = 1'b0;
						if (l.auto_pre) begin // RL9
							next_l.bank_open[l.bank] = 1'b0;
						end
					end
				end
			end
			// command decode, taken only on the rising crossing
			if (!cmd_pins.cke) begin // RL4
				if (l.bank_open != '0 || l.busy) begin
					next_l.pwr = PWR_PD_ACT;
				end else if (cmd == CMD_REF) begin
					next_l.pwr = PWR_SELF;
				end else begin
					next_l.pwr = PWR_PD_PRE;
				end
			end else begin
				case (cmd) // RL1
					CMD_ACT: begin
						next_l.bank_open[cmd_pins.bank_select] = 1'b1; // RL5 RL17
						next_l.open_row[cmd_pins.bank_select] = cmd_pins.addr[ROW_W-1:0]; // RL6
					end
					CMD_PRE: begin
						if (cmd_pins.addr[AP_BIT]) begin // RL10
							next_l.bank_open = '0;
						end else begin
							next_l.bank_open[cmd_pins.bank_select] = 1'b0; // RL5
						end
					end
					CMD_RD, CMD_WR: begin
						next_l.busy = 1'b1;
						next_l.is_write = (cmd == CMD_WR);
						next_l.bank = cmd_pins.bank_select; // RL5
						next_l.col = cmd_pins.addr[COL_W-1:0]; // RL7
						next_l.auto_pre = cmd_pins.addr[AP_BIT]; // RL9
						next_l.beat = 2'h0;
						next_l.last_beat = chop ? 2'h1 : 2'h3; // RL11 RL12
						// write data arrives one cycle ahead of read data
						next_l.wait_cnt = (cmd == CMD_WR) ? lat - LAT_TWO : lat - LAT_ONE; // RL14 RL18
						for (int i = 0; i < BURST; i++) begin
							// RL19
							next_l.pf[i] = l.mem[{cmd_pins.bank_select,
								beat_col(cmd_pins.addr[2:0], 3'(i), l.mr[0][MR_BT_BIT])}];
						end
					end
					CMD_REF: begin
						next_l.ref_tgl = ~l.ref_tgl;
					end
					CMD_MRS: begin
						if (!cmd_pins.bank_select[2]) begin
							next_l.mr[cmd_pins.bank_select[1:0]] = cmd_pins.addr; // RL8
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			l <= '{cke_prev: 1'b0, pwr: PWR_ON, mr: {4{MR_RESET}}, default: '0};
		end else begin
			l <= next_l;
		end
	end

	assign rdata = l.rd;

	// ==========================================
	// core domain: status crossing and refresh watch
	typedef struct packed {
		logic [BANKS+2:0] sync1;
		logic [BANKS+2:0] sync2;
		logic ref_seen;
		logic [15:0] idle_cnt;
		dci_status_t st;
	} dci_core_t;

	dci_core_t c;
	dci_core_t next_c;
	logic [15:0] limit;

	always_comb begin
		next_c = c;
		// each bit is an independent level; refresh is a toggle
		next_c.sync1 = {l.bank_open, l.pwr == PWR_PD_PRE || l.pwr == PWR_PD_ACT, l.pwr == PWR_SELF, l.ref_tgl};
		next_c.sync2 = c.sync1;
		next_c.ref_seen = c.sync2[0];
		next_c.st.bank_open = c.sync2[BANKS+2:3];
		next_c.st.power_down = c.sync2[2];
		next_c.st.self_refresh = c.sync2[1];
		// RL15 RL16
		limit = extended_temp ? 16'(OVERDUE_EXT_CYC) : 16'(OVERDUE_NORMAL_CYC);
		if (c.sync2[0] != c.ref_seen) begin
			next_c.st.refresh_count = c.st.refresh_count + 16'h0001;
			next_c.idle_cnt = 16'h0000;
		end else if (c.sync2[1]) begin
			// self refresh keeps the array alive on its own
			next_c.idle_cnt = 16'h0000;
		end else if (c.idle_cnt != 16'hFFFF) begin
			next_c.idle_cnt = c.idle_cnt + 16'h0001;
		end
		next_c.st.refresh_overdue = (c.idle_cnt >= limit);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	assign status = c.st;
endmodule // dci_cmd_addr_if

/* File: logic/dci_pkg.sv */
// constants and carrier types for the ddr3 command/address interface
// assumes one core clock and one link clock taken from the true clock pin
package dci_pkg;
	// ==========================================
	// geometry
	localparam int BANKS = 8;
	localparam int ROW_W = 12;
	localparam int COL_W = 10;
	localparam int ADDR_W = 13;
	localparam int BA_W = 3;
	localparam int DQ_W = 16;
	localparam int BURST = 8;
	localparam int MEM_WORDS = BANKS * BURST;
	localparam int AP_BIT = 10;
	localparam int CHOP_BIT = 12;
	// ==========================================
	// mode register fields
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_AL_LSB = 3;
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_FIXED4 = 2'h2;
	localparam logic [1:0] AL_ZERO = 2'h0;
	localparam logic [1:0] AL_CL1 = 2'h1;
	localparam logic [1:0] AL_CL2 = 2'h2;
	localparam logic [4:0] CL_667 = 5'h09;
	localparam logic [4:0] CL_800 = 5'h0B;
	localparam logic [4:0] CL_933 = 5'h0D;
	localparam logic [4:0] LAT_ONE = 5'h01;
	localparam logic [4:0] LAT_TWO = 5'h02;
	localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;
	// ==========================================
	// refresh timing on the core clock
	localparam int CLK_PERIOD_PS = 4000;
	localparam int REFI_NORMAL_NS = 7800;
	localparam int REFI_EXT_NS = 3900;
	localparam int POSTPONE_MAX = 9;
	localparam int REFI_NORMAL_CYC = REFI_NORMAL_NS * 1000 / CLK_PERIOD_PS;
	localparam int REFI_EXT_CYC = REFI_EXT_NS * 1000 / CLK_PERIOD_PS;
	localparam int OVERDUE_NORMAL_CYC = REFI_NORMAL_CYC * POSTPONE_MAX;
	localparam int OVERDUE_EXT_CYC = REFI_EXT_CYC * POSTPONE_MAX;
	// ==========================================
	// types
	typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_REF, CMD_MRS} dci_cmd_t;
	typedef enum logic [1:0] {PWR_ON, PWR_PD_PRE, PWR_PD_ACT, PWR_SELF} dci_pwr_t;
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BA_W-1:0] bank_select;
		logic [ADDR_W-1:0] addr;
	} dci_cmd_pins_t;
	typedef struct packed {
		logic [DQ_W-1:0] rise;
		logic [DQ_W-1:0] fall;
		logic [1:0] byte_write_mask_rise;
		logic [1:0] byte_write_mask_fall;
	} dci_wdata_t;
	typedef struct packed {
		logic [DQ_W-1:0] rise;
		logic [DQ_W-1:0] fall;
		logic dq_oe;
		logic dqs_rise;
		logic dqs_fall;
		logic dqs_oe;
	} dci_rdata_t;
	typedef struct packed {
		logic [BANKS-1:0] bank_open;
		logic power_down;
		logic self_refresh;
		logic [15:0] refresh_count;
		logic refresh_overdue;
	} dci_status_t;
endpackage

/* File: testbench/dci_ctl.sv */
// controller model driving the device's command and write-data pins
// assumes link_clk is the true clock and the device samples on its rise
`timescale 1ns/1ns
module dci_ctl (
	// link clock
	input wire logic link_clk,
	// pins toward the device
	output dci_pkg::dci_cmd_pins_t cmd_pins,
	output dci_pkg::dci_wdata_t wdata
);
	import dci_pkg::*;
	int seed = 49247;
	initial begin
		cmd_pins = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'($random(seed)), 13'($random(seed))};
		wdata = 36'({$random(seed), $random(seed)});
	end
	task automatic step(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask
	// =========================================
	// commands
	task automatic cmd(input logic cs_n, input logic [2:0] op, input logic [2:0] ba, input logic [12:0] a);
		step(1);
		cmd_pins.cs_n = cs_n;
		{cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} = op;
		cmd_pins.bank_select = ba;
		cmd_pins.addr = a;
		step(1);
		cmd_pins.cs_n = 1'b1;
		// released lines must not keep showing the old value
		cmd_pins.addr = ~a;
	endtask
	task automatic set_cke(input logic v);
		cmd_pins.cke = v;
		step(2);
	endtask
	// cke low with all banks idle: deselect for power-down, refresh for self refresh
	// refresh must share the edge where cke is first sampled low, else it lands in suspension
	task automatic low_power(input logic self_ref);
		step(1);
		cmd_pins.cke = 1'b0;
		cmd_pins.cs_n = !self_ref;
		{cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} = 3'h1;
		step(1);
		cmd_pins.cs_n = 1'b1;
		step(4);
	endtask
	// write beats, one cycle ahead of read latency; caller spaces activates
	task automatic put(input logic [127:0] d, input logic [15:0] m);
		step(7);
		for (int k = 0; k < 4; k++) begin
			wdata = {d[32*k+:16], d[32*k+16+:16], m[4*k+:2], m[4*k+2+:2]};
			step(1);
		end
		wdata = ~wdata;
	endtask
endmodule // dci_ctl

/* File: testbench/dci_cmd_addr_if_sva.sv */
// checker for the ddr3 command/address block, bound to its top ports
// assumes mode registers at reset apart from the burst field
`timescale 1ns/1ns
module dci_cmd_addr_if_sva #(
	parameter int OVERDUE_NORMAL_CYC = 200,
	parameter int OVERDUE_EXT_CYC = 100
) (
	// clocks and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic link_clk,
	// watched ports
	input wire logic extended_temp,
	input wire dci_pkg::dci_status_t status,
	input wire dci_pkg::dci_cmd_pins_t cmd_pins,
	input wire dci_pkg::dci_wdata_t wdata,
	input wire dci_pkg::dci_rdata_t rdata
);
	import dci_pkg::*;
	logic cke_q;
	logic sr_seen;
	logic rd_now;
	logic [15:0] quiet_cnt;
	logic [15:0] lim;
	// =========================================
	// helpers
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) cke_q <= 1'b0;
		else cke_q <= cmd_pins.cke;
	end
	assign rd_now = cke_q && cmd_pins.cke && !cmd_pins.cs_n && cmd_pins.ras_n && !cmd_pins.cas_n && cmd_pins.we_n;
	assign lim = extended_temp ? 16'(OVERDUE_EXT_CYC) : 16'(OVERDUE_NORMAL_CYC);
	// self refresh may restart the overdue count, so stop judging after it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			quiet_cnt <= 16'h0000;
			sr_seen <= 1'b0;
		end else begin
			sr_seen <= sr_seen | status.self_refresh;
			if ($changed(status.refresh_count)) quiet_cnt <= 16'h0000;
			else if (quiet_cnt != 16'hFFFF) quiet_cnt <= quiet_cnt + 16'h0001;
		end
	end
	sequence rd_take;
		rd_now;
	endsequence
	sequence full_burst;
		rdata.dq_oe [*4] ##1 !rdata.dq_oe;
	endsequence
	// =========================================
	// link side
	chk_read_latency: assert property (@(posedge link_clk) disable iff (!reset_n) rd_take |-> ##10 rdata.dq_oe)
		else $error("read data not out at latency");
	chk_burst_eight: assert property (@(posedge link_clk) disable iff (!reset_n)
		rd_take and cmd_pins.addr[12] |-> ##10 full_burst)
		else $error("full burst length wrong");
	chk_read_cause: assert property (@(posedge link_clk) disable iff (!reset_n) $rose(rdata.dq_oe) |-> $past(rd_now, 10))
		else $error("read data without a taken read");
	chk_strobe_levels: assert property (@(posedge link_clk) disable iff (!reset_n)
		rdata.dqs_oe |-> rdata.dqs_rise && !rdata.dqs_fall)
		else $error("strobe levels wrong");
	chk_strobe_pair: assert property (@(posedge link_clk) disable iff (!reset_n) rdata.dq_oe == rdata.dqs_oe)
		else $error("strobe not driven with data");
	// =========================================
	// core side
	chk_refresh_step: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(status.refresh_count) |-> status.refresh_count == $past(status.refresh_count) + 16'h0001)
		else $error("refresh count jumped");
	chk_self_idle: assert property (@(posedge clk) disable iff (!reset_n) $rose(status.self_refresh) |-> status.bank_open == 8'h00)
		else $error("self refresh with open bank");
	chk_overdue_late: assert property (@(posedge clk) disable iff (!reset_n)
		!sr_seen && extended_temp == $past(extended_temp, 4) && quiet_cnt > lim + 16'h0008 |-> status.refresh_overdue)
		else $error("overdue flag missing");
	chk_overdue_early: assert property (@(posedge clk) disable iff (!reset_n) !sr_seen && quiet_cnt > 16'h0008
		&& quiet_cnt + 16'h0008 < lim |-> !status.refresh_overdue)
		else $error("overdue flag too soon");
endmodule // dci_cmd_addr_if_sva
bind dci_cmd_addr_if dci_cmd_addr_if_sva #(.OVERDUE_NORMAL_CYC(OVERDUE_NORMAL_CYC), .OVERDUE_EXT_CYC(OVERDUE_EXT_CYC))
	dci_cmd_addr_if_sva_i (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .extended_temp(extended_temp),
	.status(status), .cmd_pins(cmd_pins), .wdata(wdata), .rdata(rdata));

/* File: testbench/tb.sv */
// self-checking bench for the ddr3 command/address block
// assumes the controller model in dci_ctl and a free-running link clock
`timescale 1ns/1ns
module tb;
	import dci_pkg::*;
	localparam logic [2:0] ACT = 3'h3, PRE = 3'h2, RD = 3'h5, WR = 3'h4, REF = 3'h1, MRS = 3'h0;
	localparam int LIM_NORMAL = 200;
	localparam int LIM_EXT = 100;
	logic clk;
	logic link_clk;
	logic reset_n;
	logic extended_temp;
	dci_status_t status;
	dci_cmd_pins_t cmd_pins;
	dci_wdata_t wdata;
	dci_rdata_t rdata;
	int error_cnt = 0;
	int checks = 0;
	int seed = 49247;
	logic [31:0] expq[$];
	logic [15:0] mem[8];
	logic [127:0] d0;
	logic [127:0] d1;
	logic [15:0] m;
	logic [15:0] rc;
	dci_cmd_addr_if #(.OVERDUE_NORMAL_CYC(LIM_NORMAL), .OVERDUE_EXT_CYC(LIM_EXT)) dci_cmd_addr_if_i (.clk(clk),
		.reset_n(reset_n),
		.extended_temp(extended_temp), .status(status), .link_clk(link_clk), .cmd_pins(cmd_pins), .wdata(wdata),
		.rdata(rdata));
	dci_ctl dci_ctl_i (.link_clk(link_clk), .cmd_pins(cmd_pins), .wdata(wdata));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = ~link_clk;
	end
	// =========================================
	// helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic go(input logic c, input logic [2:0] op, input logic [2:0] ba, input logic [12:0] a);
		dci_ctl_i.cmd(c, op, ba, a);
	endtask
	task automatic settle();
		repeat (12) @(posedge clk);
		#1;
	endtask
	task automatic drain();
		repeat (30) @(posedge link_clk);
		check("read_left", expq.size(), 0);
	endtask
	function automatic logic [2:0] seq_col(input logic [2:0] c, input logic [2:0] i);
		return {c[2] ^ i[2], c[1:0] + i[1:0]};
	endfunction
	always @(posedge link_clk) begin
		if (rdata.dq_oe === 1'b1) begin
			if (expq.size() == 0) check("read_beats", 32'h1, 32'h0);
			else check("read_word", {rdata.rise, rdata.fall}, expq.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("watchdog expired");
		give_verdict();
	end
	// =========================================
	// tests
	initial begin
		reset_n = 1'b0;
		extended_temp = 1'b0;
		repeat (20) @(posedge clk);
		#1 reset_n = 1'b1;
		settle();
		check("status_reset", 32'(status), 32'h0);
		dci_ctl_i.set_cke(1'b1);
		for (int b = 1; b < 8; b += 2) go(1'b0, ACT, 3'(b), {1'b0, 12'($random(seed))});
		go(1'b1, ACT, 3'h0, 13'h0000);
		settle();
		check("bank_open", 32'(status.bank_open), 32'hAA);
		go(1'b0, PRE, 3'h3, 13'h0000);
		settle();
		check("bank_one", 32'(status.bank_open), 32'hA2);
		go(1'b0, PRE, 3'h0, 13'h0400);
		settle();
		check("bank_all", 32'(status.bank_open), 32'h0);
		$display("test banks done");
		d0 = {$random(seed), $random(seed), $random(seed), $random(seed)};
		d1 = {$random(seed), $random(seed), $random(seed), $random(seed)};
		m = 16'($random(seed));
		go(1'b0, ACT, 3'h2, 13'h0123);
		dci_ctl_i.step(2);
		go(1'b0, WR, 3'h2, 13'h1000);
		dci_ctl_i.put(d0, 16'h0000);
		go(1'b0, WR, 3'h2, 13'h1000);
		dci_ctl_i.put(d1, m);
		for (int i = 0; i < 16; i++) mem[i/2][8*(i%2)+:8] = m[i] ? d0[8*i+:8] : d1[8*i+:8];
		for (int k = 0; k < 8; k += 2) expq.push_back({mem[seq_col(3'h5, 3'(k))], mem[seq_col(3'h5, 3'(k+1))]});
		go(1'b0, RD, 3'h2, 13'h1405);
		drain();
		settle();
		check("auto_close", 32'(status.bank_open), 32'h0);
		go(1'b0, MRS, 3'h0, 13'h0001);
		dci_ctl_i.step(4);
		go(1'b0, ACT, 3'h2, 13'h0123);
		dci_ctl_i.step(2);
		for (int k = 0; k < 4; k += 2) expq.push_back({mem[k], mem[k+1]});
		go(1'b0, RD, 3'h2, 13'h0000);
		drain();
		// interleaved order, fixed eight-beat bursts
		go(1'b0, MRS, 3'h0, 13'h0008);
		dci_ctl_i.step(4);
		for (int k = 0; k < 8; k += 2) expq.push_back({mem[3'h5 ^ 3'(k)], mem[3'h5 ^ 3'(k+1)]});
		go(1'b0, RD, 3'h2, 13'h1005);
		drain();
		go(1'b0, PRE, 3'h0, 13'h0400);
		$display("test data done");
		@(posedge clk);
		#1 extended_temp = 1'b1;
		rc = status.refresh_count;
		go(1'b0, REF, 3'h0, 13'h0000);
		settle();
		check("refresh_count", 32'(status.refresh_count), 32'(rc + 16'h0001));
		repeat (60) @(posedge clk);
		#1;
		check("overdue_low", 32'(status.refresh_overdue), 32'h0);
		repeat (60) @(posedge clk);
		#1;
		check("overdue_high", 32'(status.refresh_overdue), 32'h1);
		dci_ctl_i.low_power(1'b0);
		settle();
		check("power_down", 32'(status.power_down), 32'h1);
		dci_ctl_i.set_cke(1'b1);
		settle();
		check("power_up", 32'(status.power_down), 32'h0);
		dci_ctl_i.low_power(1'b1);
		settle();
		check("self_refresh", 32'(status.self_refresh), 32'h1);
		dci_ctl_i.set_cke(1'b1);
		settle();
		check("self_exit", 32'(status.self_refresh), 32'h0);
		$display("test power done");
		give_verdict();
	end
endmodule // tb
